// ==== rx_wake_pkg.sv ====
// constants for the standby-capable serial receiver
package rx_wake_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register indices on the plain register port
  localparam logic [3:0] A_OUT_LEVEL = 4'h0;
  localparam logic [3:0] A_OUT_GATE = 4'h1;
  localparam logic [3:0] A_START = 4'h2;
  localparam logic [3:0] A_STOP = 4'h3;
  localparam logic [3:0] A_COMM = 4'h4;
  localparam logic [3:0] A_DATA = 4'h5;
  localparam logic [3:0] A_PRESCALE = 4'h6;
  localparam logic [3:0] A_STANDBY = 4'h7;
  localparam logic [3:0] A_STATUS = 4'h8;
  localparam logic [3:0] A_FLAG_CLR = 4'h9;
  // reset values
  localparam logic [15:0] OUT_LEVEL_RST = 16'h0F0F;
  localparam logic [15:0] OUT_GATE_RST = 16'h0000;
  localparam logic [6:0] DIV_RST = 7'h4F;
  localparam logic [3:0] PRS_RST = 4'h0;
  // field positions
  localparam int RX_CH_BIT = 1;
  localparam int COMM_RXE = 0;
  localparam int COMM_EOC = 1;
  localparam int COMM_PAR_LO = 2;
  localparam int COMM_LSB = 4;
  localparam int COMM_LEN7 = 5;
  localparam int DIV_LO = 9;
  localparam int SBY_WAKE = 0;
  localparam int SBY_SUPP = 1;
  localparam int ST_PE = 0;
  localparam int ST_FE = 1;
  localparam int ST_OV = 2;
  localparam int ST_FULL = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_EN = 5;
  // parity modes
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;
  // wake-mode line rate and divider table values
  localparam int WAKE_BPS = 4800;
  localparam logic [6:0] WAKE_DIV_A = 7'h4F;
  localparam logic [6:0] WAKE_DIV_B = 7'h69;
  typedef enum logic [2:0] {
    st_idle, st_start, st_data, st_par, st_stop
  } rx_state_t;
endpackage

// ==== op_clock_tick.sv ====
// prescaler giving one pulse per channel operation clock period
`timescale 1ns/1ns
module op_clock_tick
  import rx_wake_pkg::*;
#(
  parameter int CNT_W = 15
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [3:0] prs_sel,
  output logic op_tick
);
  initial begin
    if (CNT_W < 1 || CNT_W > 15) begin
      $error("op_clock_tick: CNT_W out of range");
    end
  end

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] mask;

  // divide by two to the power of prs_sel
  always_comb begin
    mask = '0;
    for (int i = 0; i < CNT_W; i++) begin
      mask[i] = (i < int'(prs_sel));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign op_tick = ((cnt_r & mask) == mask);
endmodule

// ==== rx_wake_uart.sv ====
// receive channel with standby wake reception and register port
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1 - output level bits never touched by receiver
// RL2 - software starts only the receive channel
// RL3 - wait four op clocks before start
// RL4 - receive on pin activity during halt
// RL5 - without wake mode, halt stops reception
// RL6 - wake mode only on channel zero
// RL7 - reprogram prescaler and divider before halt
// RL8 - error select and suppress gate error interrupt
// RL9 - set wake control just before halt
// RL10 - start receive channel before wake use
// RL11 - start bit during halt begins reception
// RL12 - wake mode needs internal fast oscillator
// RL13 - wake mode line rate is 4800 bps
// RL14 - wake start outside halt may corrupt
// RL15 - suppress blocks error flags and interrupt
// RL16 - clear flags, read data before wake
// RL17 - valid edge in halt raises wake request
// RL18 - short pulse starts nothing, stays awake
// RL19 - divider 79 for 24/12/6/3 MHz
// RL20 - divider 105 for 16/8/4/2/1 MHz
// RL21 - narrow deviation window for worse oscillator
// RL22 - transmitter stays inside deviation window
// RL23 - sample bit centres from start edge
// RL24 - rate is op clock/(divider+1)/2
// RL25 - divider values zero and one forbidden
// RL26 - select off: no error irq, end irq
module rx_wake_uart
  import rx_wake_pkg::*;
#(
  parameter bit WAKE_CAPABLE = 1'b1,
  parameter int PRS_CNT_W = 15
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic serial_receive_pin,
  input wire logic halt_standby,
  output logic wake_request,
  output logic receive_end_interrupt,
  output logic receive_error_interrupt,
  output logic [3:0] serial_data_out,
  output logic [3:0] clock_output_bits,
  output logic [3:0] serial_output_gate
);
  initial begin
    if (PRS_CNT_W < 15) begin
      $error("rx_wake_uart: prescaler too short");
    end
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a);
    hit = reg_wr && (reg_addr == a);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // software registers
  logic [15:0] out_level_r;
  logic [15:0] out_gate_r;
  logic rx_en_r;
  logic eoc_r;
  logic [1:0] par_mode_r;
  logic lsb_first_r;
  logic len7_r;
  logic [6:0] div_r;
  logic [3:0] prs_r;
  logic wake_ctrl_r;
  logic suppress_r;
  logic chan_en_r;

  // output level and gate only follow software writes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      out_level_r <= OUT_LEVEL_RST;
      out_gate_r <= OUT_GATE_RST;
    end else begin
      if (hit(A_OUT_LEVEL)) begin
        out_level_r <= reg_wdata; // RL1
      end
      if (hit(A_OUT_GATE)) begin
        out_gate_r <= reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_en_r <= 1'b0;
      eoc_r <= 1'b0;
      par_mode_r <= PAR_NONE;
      lsb_first_r <= 1'b1;
      len7_r <= 1'b0;
    end else if (hit(A_COMM)) begin
      rx_en_r <= reg_wdata[COMM_RXE];
      eoc_r <= reg_wdata[COMM_EOC];
      par_mode_r <= reg_wdata[COMM_PAR_LO +: 2];
      lsb_first_r <= reg_wdata[COMM_LSB];
      len7_r <= reg_wdata[COMM_LEN7];
    end
  end

  // divider and prescaler are retuned by software for wake mode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_r <= DIV_RST;
      prs_r <= PRS_RST;
    end else begin
      if (hit(A_DATA)) begin
        div_r <= reg_wdata[DIV_LO +: 7]; // RL7 RL13
      end
      if (hit(A_PRESCALE)) begin
        prs_r <= reg_wdata[3:0]; // RL7
      end
    end
  end

  // wake control is hard-wired off on channels without wake support
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wake_ctrl_r <= 1'b0;
      suppress_r <= 1'b0;
    end else if (hit(A_STANDBY)) begin
      wake_ctrl_r <= reg_wdata[SBY_WAKE] & WAKE_CAPABLE; // RL6
      suppress_r <= reg_wdata[SBY_SUPP] & WAKE_CAPABLE; // RL6
    end
  end

  // only the receive channel bit of the start trigger has effect
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chan_en_r <= 1'b0;
    end else if (hit(A_START) && reg_wdata[RX_CH_BIT]) begin
      chan_en_r <= 1'b1; // RL2 RL10
    end else if (hit(A_STOP) && reg_wdata[RX_CH_BIT]) begin
      chan_en_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin synchroniser and operation clock
  logic pin_meta_r;
  logic pin_sync_r;
  logic pin_prev_r;
  logic op_tick;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
      pin_prev_r <= 1'b1;
    end else begin
      pin_meta_r <= serial_receive_pin;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  op_clock_tick #(
    .CNT_W(PRS_CNT_W)
  ) u_tick (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .prs_sel(prs_r),
    .op_tick(op_tick)
  );

  ////////////////////////////////////////////////////////////////////
  // receive engine
  rx_state_t state_r;
  logic [7:0] cnt_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic par_bit_r;
  logic fall;
  logic rx_allowed;
  logic [7:0] half_bit;
  logic [7:0] full_bit;
  logic [3:0] last_bit;
  logic frame_done;
  logic [7:0] frame_data;
  logic par_err;
  logic stop_err;

  assign fall = pin_prev_r & ~pin_sync_r;
  // halt stops the channel unless wake reception is armed
  assign rx_allowed = chan_en_r & rx_en_r
                      & (~halt_standby | wake_ctrl_r); // RL4 RL5
  // counts end at zero so a 256-tick bit still fits eight bits
  assign half_bit = {1'b0, div_r}; // RL24
  assign full_bit = {div_r, 1'b1}; // RL24
  assign last_bit = len7_r ? 4'h6 : 4'h7;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !rx_allowed) begin
      state_r <= st_idle; // RL5
      cnt_r <= 8'h00;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      par_bit_r <= 1'b0;
    end else begin
      case (state_r)
        st_idle: begin
          // a start outside halt with wake armed is still taken
          if (fall) begin
            state_r <= st_start; // RL11 RL14
            cnt_r <= half_bit; // RL23
          end
        end
        st_start: begin
          if (op_tick) begin
            if (cnt_r != 8'h00) begin
              cnt_r <= cnt_r - 8'h01;
            end else if (pin_sync_r) begin
              state_r <= st_idle; // RL18
            end else begin
              state_r <= st_data;
              cnt_r <= full_bit;
              bit_r <= 4'h0;
            end
          end
        end
        st_data: begin
          if (op_tick) begin
            if (cnt_r != 8'h00) begin
              cnt_r <= cnt_r - 8'h01;
            end else begin
              cnt_r <= full_bit; // RL23
              if (lsb_first_r) begin
                shift_r <= {pin_sync_r, shift_r[7:1]};
              end else begin
                shift_r <= {shift_r[6:0], pin_sync_r};
              end
              bit_r <= bit_r + 4'h1;
              if (bit_r == last_bit) begin
                state_r <= (par_mode_r == PAR_NONE) ? st_stop : st_par;
              end
            end
          end
        end
        st_par: begin
          if (op_tick) begin
            if (cnt_r != 8'h00) begin
              cnt_r <= cnt_r - 8'h01;
            end else begin
              cnt_r <= full_bit;
              par_bit_r <= pin_sync_r;
              state_r <= st_stop;
            end
          end
        end
        st_stop: begin
          if (op_tick) begin
            if (cnt_r != 8'h00) begin
              cnt_r <= cnt_r - 8'h01;
            end else begin
              state_r <= st_idle;
            end
          end
        end
        default: begin
          state_r <= st_idle;
        end
      endcase
    end
  end

  assign frame_done = rx_allowed && op_tick && (state_r == st_stop)
                      && (cnt_r == 8'h00);
  // seven-bit frames shifted in from the top sit one place high
  assign frame_data = (len7_r && lsb_first_r) ? {1'b0, shift_r[7:1]}
                      : (len7_r ? {1'b0, shift_r[6:0]} : shift_r);
  assign stop_err = ~pin_sync_r;

  always_comb begin
    par_err = 1'b0;
    case (par_mode_r)
      PAR_EVEN: par_err = ^{frame_data, par_bit_r};
      PAR_ODD: par_err = ~^{frame_data, par_bit_r};
      default: par_err = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // received data, flags and events
  logic [7:0] rx_data_r;
  logic full_r;
  logic pe_r;
  logic fe_r;
  logic ov_r;
  logic any_err;
  logic rd_data_hit;
  logic [2:0] clr;

  assign rd_data_hit = reg_rd && (reg_addr == A_DATA);
  assign clr = hit(A_FLAG_CLR) ? reg_wdata[2:0] : 3'b000;
  assign any_err = par_err | stop_err | full_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rx_data_r <= 8'h00;
      full_r <= 1'b0;
    end else if (frame_done) begin
      rx_data_r <= frame_data;
      full_r <= 1'b1;
    end else if (rd_data_hit) begin
      full_r <= 1'b0;
    end
  end

  // a new error wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pe_r <= 1'b0;
      fe_r <= 1'b0;
      ov_r <= 1'b0;
    end else begin
      pe_r <= (frame_done & par_err & ~suppress_r)
              | (pe_r & ~clr[ST_PE]); // RL15
      fe_r <= (frame_done & stop_err & ~suppress_r)
              | (fe_r & ~clr[ST_FE]); // RL15
      ov_r <= (frame_done & full_r & ~suppress_r)
              | (ov_r & ~clr[ST_OV]); // RL15
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      receive_end_interrupt <= 1'b0;
      receive_error_interrupt <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      // end interrupt fires even when the error interrupt is masked
      receive_end_interrupt <= frame_done; // RL26
      receive_error_interrupt <= frame_done & any_err
                                 & eoc_r & ~suppress_r; // RL8 RL15 RL26
      wake_request <= halt_standby & wake_ctrl_r & rx_allowed
                      & fall & (state_r == st_idle); // RL17 RL4
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read port
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        A_OUT_LEVEL: reg_rdata <= out_level_r;
        A_OUT_GATE: reg_rdata <= out_gate_r;
        A_START: reg_rdata <= 16'h0000;
        A_STOP: reg_rdata <= 16'h0000;
        A_COMM: reg_rdata <= {10'h000, len7_r, lsb_first_r,
                              par_mode_r, eoc_r, rx_en_r};
        A_DATA: reg_rdata <= {div_r, 1'b0, rx_data_r};
        A_PRESCALE: reg_rdata <= {12'h000, prs_r};
        A_STANDBY: reg_rdata <= {14'h0000, suppress_r, wake_ctrl_r};
        A_STATUS: reg_rdata <= {10'h000, chan_en_r,
                                (state_r != st_idle), full_r,
                                ov_r, fe_r, pe_r};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  assign serial_data_out = out_level_r[3:0];
  assign clock_output_bits = out_level_r[11:8];
  assign serial_output_gate = out_gate_r[3:0];
endmodule

// ==== rx_wake_checker.sv ====
// concurrent checks on the standby wake receiver ports
`timescale 1ns/1ns
module rx_wake_checker
  import rx_wake_pkg::*;
#(
  parameter bit WAKE_CAPABLE = 1'b1,
  parameter int PRS_CNT_W = 15
) (
  input logic ref_clk,
  input logic sys_rst,
  input logic [ADDR_W-1:0] reg_addr,
  input logic [DATA_W-1:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [DATA_W-1:0] reg_rdata,
  input logic serial_receive_pin,
  input logic halt_standby,
  input logic wake_request,
  input logic receive_end_interrupt,
  input logic receive_error_interrupt,
  input logic [3:0] serial_data_out,
  input logic [3:0] clock_output_bits,
  input logic [3:0] serial_output_gate
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // shadow of control bits the ports do not show
  logic wake_r, supp_r, eoc_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wake_r <= 1'b0;
      supp_r <= 1'b0;
    end else if (reg_wr && reg_addr == A_STANDBY) begin
      wake_r <= reg_wdata[SBY_WAKE] & WAKE_CAPABLE;
      supp_r <= reg_wdata[SBY_SUPP] & WAKE_CAPABLE;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      eoc_r <= 1'b0;
    end else if (reg_wr && reg_addr == A_COMM) begin
      eoc_r <= reg_wdata[COMM_EOC];
    end
  end
////////////////////////////////////////
  property p_lvl;
    !($past(reg_wr) && $past(reg_addr) == A_OUT_LEVEL)
      |-> $stable({serial_data_out, clock_output_bits});
  endproperty
  a_lvl: assert property (p_lvl) else $error("level bits moved");
  property p_halt;
    (halt_standby && !wake_r) [*3] |-> !receive_end_interrupt;
  endproperty
  a_halt: assert property (p_halt) else $error("frame end in halt");
  property p_wake;
    wake_request |-> $past(halt_standby) && $past(wake_r);
  endproperty
  a_wake: assert property (p_wake) else $error("stray wake");
  property p_wpulse;
    wake_request |=> !wake_request;
  endproperty
  a_wpulse: assert property (p_wpulse) else $error("wake too long");
  property p_supp;
    supp_r && $past(supp_r) |-> !receive_error_interrupt;
  endproperty
  a_supp: assert property (p_supp) else $error("error irq suppressed");
  property p_eoc;
    !eoc_r && !$past(eoc_r) |-> !receive_error_interrupt;
  endproperty
  a_eoc: assert property (p_eoc) else $error("error irq unselected");
  property p_errend;
    receive_error_interrupt |-> receive_end_interrupt;
  endproperty
  a_errend: assert property (p_errend) else $error("error irq alone");
  property p_trig;
    $past(reg_rd) && ($past(reg_addr) == A_START || $past(reg_addr) > A_FLAG_CLR)
      |-> reg_rdata == '0;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger read nonzero");
endmodule

bind rx_wake_uart rx_wake_checker #(.WAKE_CAPABLE(WAKE_CAPABLE), .PRS_CNT_W(PRS_CNT_W)) u_chk (
  .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .serial_receive_pin, .halt_standby, .wake_request, .receive_end_interrupt,
  .receive_error_interrupt, .serial_data_out, .clock_output_bits, .serial_output_gate);

// ==== uart_tx_model.sv ====
// behavioural remote transmitter on the receive pin
`timescale 1ns/1ns
module uart_tx_model (
  input logic ref_clk,
  output logic line
);
  initial line = 1'b1;
////////////////////////////////////////
  // caller picks bit_cyc to match the receiver rate exactly
  task automatic send(input logic [9:0] bits, input int n, input int bit_cyc);
    @(posedge ref_clk);
    line <= 1'b0;
    repeat (bit_cyc) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      repeat (bit_cyc) @(posedge ref_clk);
    end
    line <= 1'b1;
  endtask
  task automatic glitch(input int len);
    @(posedge ref_clk);
    line <= 1'b0;
    repeat (len) @(posedge ref_clk);
    line <= 1'b1;
  endtask
endmodule

// ==== testbench.sv ====
// self-checking bench for the standby wake receiver
`timescale 1ns/1ns
module testbench
  import rx_wake_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic halt = 1'b0;
  logic rd_seen = 1'b0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic pin, wake, end_irq, err_irq, wake1;
  logic [3:0] sdo, cko, gate;
  logic [DATA_W-1:0] rq[$];
  logic fq[$];
  int mismatches = 0;
  int comparisons = 0;
  int wakes = 0;
  int wakes1 = 0;
  int seed = 32'hf151a959;
  rx_wake_uart u_dut (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .serial_receive_pin(pin), .halt_standby(halt), .wake_request(wake),
    .receive_end_interrupt(end_irq), .receive_error_interrupt(err_irq),
    .serial_data_out(sdo), .clock_output_bits(cko), .serial_output_gate(gate));
  // second channel without wake support sees the same traffic
  rx_wake_uart #(.WAKE_CAPABLE(1'b0)) u_dut1 (.ref_clk, .sys_rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata(), .serial_receive_pin(pin), .halt_standby(halt),
    .wake_request(wake1), .receive_end_interrupt(), .receive_error_interrupt(),
    .serial_data_out(), .clock_output_bits(), .serial_output_gate());
  uart_tx_model u_tx (.ref_clk, .line(pin));
  initial forever #5 ref_clk = ~ref_clk;
////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (rd_seen) chk("rdata", rq.pop_front(), reg_rdata);
    rd_seen <= reg_rd;
    if (end_irq && fq.size() == 0) chk("stray frame end", 16'h0, 16'h1);
    else if (end_irq) chk("error irq", {15'h0, fq.pop_front()}, {15'h0, err_irq});
    if (wake) wakes++;
    if (wake1) wakes1++;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    rq.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  // ev: 0 no frame end, 1 end without error irq, 2 end with error irq
  task automatic frame(input logic [7:0] d, input logic [1:0] pm, input logic flip,
    input logic stop, input int bc, input int ev);
    logic p;
    p = (pm == PAR_ZERO) ? 1'b0 : (pm == PAR_EVEN) ? ^d : ~^d;
    if (ev > 0) fq.push_back(ev == 2);
    if (pm == PAR_NONE) u_tx.send({1'b0, stop, d}, 9, bc);
    else u_tx.send({stop, p ^ flip, d}, 10, bc);
    repeat (40) begin
      if (fq.size() == 0) return;
      @(posedge ref_clk);
    end
    chk("frame end wait", 16'h1, 16'h0);
    close_out();
  endtask
  initial begin
    logic [7:0] b;
    int n;
    logic [10:0] cfg [3] = '{{7'd2, 4'd0}, {7'd2, 4'd1}, {7'd5, 4'd2}};
    logic [6:0] wd [2] = '{WAKE_DIV_A, WAKE_DIV_B};
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk("out bits", 16'h00FF, {4'h0, gate, cko, sdo});
    rd(A_OUT_LEVEL, OUT_LEVEL_RST);
    rd(A_OUT_GATE, OUT_GATE_RST);
    rd(A_START, 16'h0);
    rd(4'hF, 16'h0);
    rd(A_DATA, {DIV_RST, 9'h0});
    wr(A_COMM, 16'h0011);
    repeat (4) @(posedge ref_clk);
    wr(A_START, 16'h0002);
    rd(A_STATUS, 16'h0020);
    foreach (cfg[i]) begin
      wr(A_PRESCALE, {12'h0, cfg[i][3:0]});
      wr(A_DATA, {cfg[i][10:4], 9'h0});
      b = $random(seed);
      frame(b, PAR_NONE, 1'b0, 1'b1, 2 * (cfg[i][10:4] + 1) << cfg[i][3:0], 1);
      rd(A_DATA, {cfg[i][10:4], 1'b0, b});
    end
    wr(A_PRESCALE, 16'h0);
    wr(A_DATA, 16'h0400);
    // line carries the bit-reversed byte for msb-first frames
    wr(A_COMM, 16'h0001);
    frame(8'hA3, PAR_NONE, 1'b0, 1'b1, 6, 1);
    rd(A_DATA, 16'h04C5);
    wr(A_COMM, 16'h0021);
    frame(8'hED, PAR_NONE, 1'b0, 1'b1, 6, 1);
    rd(A_DATA, 16'h045B);
    wr(A_COMM, 16'h0031);
    frame(8'hDB, PAR_NONE, 1'b0, 1'b1, 6, 1);
    rd(A_DATA, 16'h045B);
    wr(A_STOP, 16'h0002);
    rd(A_STATUS, 16'h0000);
    frame(8'h66, PAR_NONE, 1'b0, 1'b1, 6, 0);
    wr(A_START, 16'h0002);
    for (int m = 0; m < 4; m++) begin
      wr(A_COMM, 16'(32'h13 | (m << COMM_PAR_LO)));
      b = $random(seed);
      frame(b, m[1:0], 1'b0, 1'b1, 6, 1);
      rd(A_DATA, {7'd2, 1'b0, b});
    end
    frame(8'hA5, PAR_ODD, 1'b1, 1'b1, 6, 2);
    rd(A_STATUS, 16'h0029);
    rd(A_DATA, 16'h04A5);
    wr(A_FLAG_CLR, 16'h0007);
    wr(A_COMM, 16'h0011);
    frame(8'h3C, PAR_NONE, 1'b0, 1'b0, 6, 1);
    rd(A_STATUS, 16'h002A);
    wr(A_FLAG_CLR, 16'h0007);
    wr(A_STANDBY, 16'h0002);
    wr(A_COMM, 16'h0013);
    frame(8'h5A, PAR_NONE, 1'b0, 1'b0, 6, 1);
    rd(A_STATUS, 16'h0028);
    rd(A_DATA, 16'h045A);
    wr(A_FLAG_CLR, 16'h0007);
    @(posedge ref_clk);
    halt <= 1'b1;
    frame(8'h81, PAR_NONE, 1'b0, 1'b1, 6, 0);
    repeat (20) @(posedge ref_clk);
    halt <= 1'b0;
    foreach (wd[i]) begin
      wr(A_DATA, {wd[i], 9'h0});
      wr(A_STANDBY, 16'h0003);
      @(posedge ref_clk);
      halt <= 1'b1;
      n = wakes;
      b = $random(seed);
      frame(b, PAR_NONE, 1'b0, 1'b1, 2 * (wd[i] + 1), 1);
      chk("wake count", 16'(n + 1), 16'(wakes));
      if (i == 1) u_tx.glitch(10);
      repeat (300) @(posedge ref_clk);
      halt <= 1'b0;
      wr(A_STANDBY, 16'h0002);
      rd(A_DATA, {wd[i], 1'b0, b});
    end
    chk("second channel wake", 16'h0, 16'(wakes1));
    close_out();
  end
endmodule
